//--- hw/rfd_pkg.sv
package rfd_pkg;
   // Instruction word layout
   localparam int WORD_W = 16;
   localparam int FADDR_W = 8;
   localparam int BANK_W = 4;
   localparam int DADDR_W = 12;
   localparam int D_BIT = 9;
   localparam int A_BIT = 8;
   // Opcode fields, upper six bits for rotates, upper seven for fill
   localparam logic [5:0] OPC_RLC = 6'h0D;
   localparam logic [5:0] OPC_RLN = 6'h11;
   localparam logic [5:0] OPC_RRC = 6'h0C;
   localparam logic [5:0] OPC_RRN = 6'h10;
   localparam logic [6:0] OPC_FILL = 7'h34;
   // Access bank split and its upper bank
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [7:0] FILL_VALUE = 8'hFF;
   // Reset values
   localparam logic [7:0] W_RESET = 8'h00;
   // Cycles from acceptance to read strobe and from read to done
   localparam int READ_DELAY = 2;
   localparam int DONE_DELAY = 3;

   typedef enum logic [2:0] {
      OP_NONE,
      rotate_left_thru_carry_op,
      rotate_left_plain_op,
      rotate_right_thru_carry_op,
      rotate_right_plain_op,
      fill_ones_op
   } rfd_op_type;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_Q1,
      PH_Q2,
      PH_Q3,
      PH_Q4
   } rfd_phase_type;
endpackage : rfd_pkg

//--- hw/rfd_rotator.sv
module rfd_rotator
   import rfd_pkg::*;
(
   input wire rfd_op_type op,
   input wire logic [7:0] src,
   input wire logic carry_in,
   output logic [7:0] result,
   output logic carry_out
);
   always_comb begin
      result = src;
      carry_out = carry_in;
      case (op)
         rotate_left_thru_carry_op: begin
            result = {src[6:0], carry_in};
            carry_out = src[7];
         end
         rotate_left_plain_op: begin
            result = {src[6:0], src[7]};
         end
         rotate_right_thru_carry_op: begin
            result = {carry_in, src[7:1]};
            carry_out = src[0];
         end
         rotate_right_plain_op: begin
            result = {src[0], src[7:1]};
         end
         fill_ones_op: begin
            result = FILL_VALUE;
         end
         default: begin
            result = src;
         end
      endcase
   end
endmodule : rfd_rotator

//--- hw/rfd_datapath.sv
// Summary of operation
// - Rotate right plain: bit 0 into bit 7
// - Rotate right carry: carry in, bit 0 out
// - Rotate left plain: bit 7 into bit 0
// - Rotate left carry: carry in, bit 7 out
// - Destination bit: 0 accumulator, 1 file
// - Bank bit: 0 access bank, 1 pointer
// - Left carry to accumulator keeps file unchanged
// - Fill writes FFh, flags untouched
// - One word, one instruction cycle
// - Decode, read, compute, write per phase
module rfd_datapath
   import rfd_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic INSTR_VALID,
   input wire logic [WORD_W-1:0] INSTR_WORD,
   output logic INSTR_READY,
   input wire logic [BANK_W-1:0] BANK_POINTER,
   output logic [DADDR_W-1:0] DMEM_ADDR,
   output logic DMEM_RD,
   input wire logic [7:0] DMEM_RDATA,
   output logic DMEM_WR,
   output logic [7:0] DMEM_WDATA,
   output logic [7:0] W_REG,
   output logic CARRY,
   output logic NEG,
   output logic ZERO,
   output logic DONE,
   output logic ILLEGAL
);
   typedef struct packed {
      rfd_phase_type phase;
      rfd_op_type op;
      logic [WORD_W-1:0] word;
      logic [DADDR_W-1:0] addr;
      logic rd;
      logic wr;
      logic [7:0] src;
      logic [7:0] result;
      logic cout;
      logic [7:0] w;
      logic c;
      logic n;
      logic z;
      logic done;
      logic illegal;
   } rfd_state_type;

   rfd_state_type st;
   rfd_state_type next_st;
   logic [7:0] rot_result;
   logic rot_carry;
   rfd_op_type in_op;

   function automatic rfd_op_type decode_op(input logic [WORD_W-1:0] word);
      rfd_op_type op;
      op = OP_NONE;
      if (word[15:10] == OPC_RLC) begin
         op = rotate_left_thru_carry_op;
      end else if (word[15:10] == OPC_RLN) begin
         op = rotate_left_plain_op;
      end else if (word[15:10] == OPC_RRC) begin
         op = rotate_right_thru_carry_op;
      end else if (word[15:10] == OPC_RRN) begin
         op = rotate_right_plain_op;
      end else if (word[15:9] == OPC_FILL) begin
         op = fill_ones_op;
      end
      return op;
   endfunction : decode_op

   function automatic logic [DADDR_W-1:0] data_addr(input logic [WORD_W-1:0] word,
                                                    input logic [BANK_W-1:0] bank);
      logic [DADDR_W-1:0] addr;
      addr = {bank, word[FADDR_W-1:0]};
      if (!word[A_BIT]) begin
         if (word[FADDR_W-1:0] < ACCESS_SPLIT) begin
            addr = {ACCESS_LOW_BANK, word[FADDR_W-1:0]};
         end else begin
            addr = {ACCESS_HIGH_BANK, word[FADDR_W-1:0]};
         end
      end
      return addr;
   endfunction : data_addr

   // File written when d is 1, fill always
   function automatic logic writes_file(input rfd_op_type op, input logic [WORD_W-1:0] word);
      return (op == fill_ones_op) || word[D_BIT];
   endfunction : writes_file

   rfd_rotator u_rotator (
      .op(st.op),
      .src(st.src),
      .carry_in(st.c),
      .result(rot_result),
      .carry_out(rot_carry)
   );

   assign in_op = decode_op(INSTR_WORD);

   always_comb begin
      next_st = st;
      next_st.rd = 1'b0;
      next_st.wr = 1'b0;
      next_st.done = 1'b0;
      next_st.illegal = 1'b0;
      case (st.phase)
         PH_Q1: begin
            next_st.addr = data_addr(st.word, BANK_POINTER);
            next_st.rd = 1'b1;
            next_st.phase = PH_Q2;
         end
         PH_Q2: begin
            next_st.src = DMEM_RDATA;
            next_st.phase = PH_Q3;
         end
         PH_Q3: begin
            next_st.result = rot_result;
            next_st.cout = rot_carry;
            next_st.wr = writes_file(st.op, st.word);
            next_st.phase = PH_Q4;
         end
         PH_Q4: begin
            if (!writes_file(st.op, st.word)) begin
               next_st.w = st.result;
            end
            if (st.op == rotate_left_thru_carry_op || st.op == rotate_right_thru_carry_op) begin
               next_st.c = st.cout;
            end
            if (st.op != fill_ones_op) begin
               next_st.n = st.result[7];
               next_st.z = (st.result == 8'h00);
            end
            next_st.done = 1'b1;
            next_st.phase = PH_IDLE;
         end
         default: begin
            next_st.phase = PH_IDLE;
         end
      endcase
      // Accept next word, back to back
      if ((st.phase == PH_IDLE || st.phase == PH_Q4) && INSTR_VALID) begin
         if (in_op == OP_NONE) begin
            next_st.illegal = 1'b1;
         end else begin
            next_st.word = INSTR_WORD;
            next_st.op = in_op;
            next_st.phase = PH_Q1;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         st <= '0;
         st.w <= W_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign INSTR_READY = (st.phase == PH_IDLE) || (st.phase == PH_Q4);
   assign DMEM_ADDR = st.addr;
   assign DMEM_RD = st.rd;
   assign DMEM_WR = st.wr;
   assign DMEM_WDATA = st.result;
   assign W_REG = st.w;
   assign CARRY = st.c;
   assign NEG = st.n;
   assign ZERO = st.z;
   assign DONE = st.done;
   assign ILLEGAL = st.illegal;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (SYS_RST);

   property p_rrn_result;
      DMEM_WR && st.op == rotate_right_plain_op |-> DMEM_WDATA == {st.src[0], st.src[7:1]};
   endproperty
   a_rrn_result: assert property (p_rrn_result) else $error("plain right rotate wrong");

   property p_rrc_carry;
      DONE && $past(st.op) == rotate_right_thru_carry_op |->
         CARRY == $past(st.src[0]) && $past(st.result) == {$past(CARRY), $past(st.src[7:1])};
   endproperty
   a_rrc_carry: assert property (p_rrc_carry) else $error("right carry rotate wrong");

   property p_rln_carry;
      DONE && $past(st.op) == rotate_left_plain_op |->
         CARRY == $past(CARRY) && $past(st.result) == {$past(st.src[6:0]), $past(st.src[7])};
   endproperty
   a_rln_carry: assert property (p_rln_carry) else $error("plain left rotate wrong");

   property p_rlc_carry;
      DONE && $past(st.op) == rotate_left_thru_carry_op |->
         CARRY == $past(st.src[7]) && $past(st.result) == {$past(st.src[6:0]), $past(CARRY)};
   endproperty
   a_rlc_carry: assert property (p_rlc_carry) else $error("left carry rotate wrong");

   property p_dest_route;
      st.phase == PH_Q4 |-> DMEM_WR == writes_file(st.op, st.word) ##1
         (DONE && ($past(DMEM_WR) || W_REG == $past(st.result)));
   endproperty
   a_dest_route: assert property (p_dest_route) else $error("destination routing wrong");

   property p_bank_sel;
      DMEM_RD |-> (st.word[A_BIT] ? DMEM_ADDR[DADDR_W-1:FADDR_W] == $past(BANK_POINTER)
                   : DMEM_ADDR[DADDR_W-1:FADDR_W] == (st.word[7] ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK));
   endproperty
   a_bank_sel: assert property (p_bank_sel) else $error("bank selection wrong");

   property p_rlc_to_w;
      st.phase == PH_Q4 && st.op == rotate_left_thru_carry_op && !st.word[D_BIT] |->
         !DMEM_WR ##1 W_REG == $past(st.result);
   endproperty
   a_rlc_to_w: assert property (p_rlc_to_w) else $error("left carry to accumulator wrote file");

   property p_fill;
      DONE && $past(st.op) == fill_ones_op |->
         $past(DMEM_WR) && $past(DMEM_WDATA) == FILL_VALUE && $stable(CARRY) && $stable(NEG) && $stable(ZERO);
   endproperty
   a_fill: assert property (p_fill) else $error("fill wrong");

   property p_timing;
      INSTR_VALID && INSTR_READY && in_op != OP_NONE |->
         ##2 DMEM_RD ##2 (DMEM_WR == writes_file(st.op, st.word)) ##1 DONE;
   endproperty
   a_timing: assert property (p_timing) else $error("instruction cycle timing wrong");

   property p_illegal;
      INSTR_VALID && INSTR_READY && in_op == OP_NONE |=> ILLEGAL && st.phase == PH_IDLE;
   endproperty
   a_illegal: assert property (p_illegal) else $error("unknown opcode accepted");

   property p_flags;
      DONE && $past(st.op) != fill_ones_op |-> ZERO == ($past(st.result) == 8'h00) && NEG == $past(st.result[7]);
   endproperty
   a_flags: assert property (p_flags) else $error("flag update wrong");

   property p_one_cycle;
      DONE |-> $past(st.phase) == PH_Q4 && $past(st.phase, 4) == PH_Q1;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("extra cycle in instruction");

   c_rlc_w: cover property (DONE && $past(st.op) == rotate_left_thru_carry_op && !$past(DMEM_WR));
   c_fill: cover property (DONE && $past(st.op) == fill_ones_op);
   c_back_to_back: cover property (DONE && st.phase == PH_Q1);
   c_illegal: cover property (ILLEGAL);
endmodule : rfd_datapath

//--- verif/rfd_mem_model.sv
module rfd_mem_model
   import rfd_pkg::*;
(
   input wire logic clk,
   input wire logic [DADDR_W-1:0] addr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic wr,
   input wire logic [7:0] wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:(1<<DADDR_W)-1];
   logic [7:0] last = 8'h00;
   // Answers at once, else shows stale inverse
   always_comb rdata = rd ? mem[addr] : ~last;
   // Plain always: the bench preloads mem directly
   always @(posedge clk) begin
      if (rd) last <= mem[addr];
      if (wr) mem[addr] <= wdata;
   end
endmodule : rfd_mem_model

//--- verif/rfd_datapath_tb.sv
module rfd_datapath_tb;
   import rfd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, sys_rst, instr_valid, instr_ready, dmem_rd, dmem_wr;
   logic carry, neg, zero, done, illegal;
   logic [WORD_W-1:0] instr_word;
   logic [BANK_W-1:0] bank_pointer;
   logic [DADDR_W-1:0] dmem_addr, rd_addr;
   logic [7:0] dmem_rdata, dmem_wdata, w_reg, wr_data;
   logic ill;
   int errors, checked, rd_k, wr_k, done_k;

   rfd_datapath dut (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .INSTR_VALID(instr_valid),
      .INSTR_WORD(instr_word), .INSTR_READY(instr_ready), .BANK_POINTER(bank_pointer),
      .DMEM_ADDR(dmem_addr), .DMEM_RD(dmem_rd), .DMEM_RDATA(dmem_rdata), .DMEM_WR(dmem_wr),
      .DMEM_WDATA(dmem_wdata), .W_REG(w_reg), .CARRY(carry), .NEG(neg), .ZERO(zero),
      .DONE(done), .ILLEGAL(illegal));
   rfd_mem_model far (.clk(sys_clk), .addr(dmem_addr), .rd(dmem_rd), .rdata(dmem_rdata),
      .wr(dmem_wr), .wdata(dmem_wdata));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic close_out;
      if (errors == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out

   task automatic check(input string nm, input logic [11:0] exp, input logic [11:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   // One word from idle, then watch six cycles
   task automatic issue(input logic [15:0] w, input logic [3:0] b);
      instr_word <= w;
      bank_pointer <= b;
      instr_valid <= 1'b1;
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      ill = 1'b0;
      rd_k = 0;
      wr_k = 0;
      done_k = 0;
      // Samples before this edge's updates land
      for (int k = 1; k <= 6; k++) begin
         @(posedge sys_clk);
         if (k == 1 && illegal === 1'b1) ill = 1'b1;
         if (dmem_rd === 1'b1) begin
            rd_k = k;
            rd_addr = dmem_addr;
         end
         if (dmem_wr === 1'b1) begin
            wr_k = k;
            wr_data = dmem_wdata;
         end
         if (done === 1'b1) done_k = k;
      end
      if (ill !== 1'b1 && done_k == 0) begin
         errors++;
         close_out;
      end
   endtask : issue

   task automatic t_reset;
      check("w", 8'h00, w_reg);
      check("flags", 3'h0, {carry, neg, zero});
      check("ready", 1'b1, instr_ready);
   endtask : t_reset

   task automatic t_rot_file;
      logic [5:0] opc [4] = '{OPC_RRN, OPC_RRC, OPC_RLN, OPC_RLC};
      logic [7:0] src [4] = '{8'hA5, 8'hA5, 8'h5A, 8'h01};
      logic [7:0] res [4] = '{8'hD2, 8'h52, 8'hB4, 8'h03};
      logic [3:0] cf = 4'b0110;
      for (int i = 0; i < 4; i++) begin
         far.mem[12'h325] = src[i];
         issue({opc[i], 2'b11, 8'h25}, 4'h3); // decode
         check("wdata", res[i], wr_data); // result
         check("addr", 12'h325, rd_addr); // pointer bank
         check("file", res[i], far.mem[12'h325]); // file dest
         check("rd_cycle", READ_DELAY, rd_k); // read phase
         check("wr_cycle", READ_DELAY + DONE_DELAY - 1, wr_k); // write phase
         check("done_cycle", READ_DELAY + DONE_DELAY, done_k); // one cycle
         check("carry", cf[i], carry); // carry
         check("neg", res[i][7], neg); // negative
         check("zero", 1'b0, zero); // zero
      end
   endtask : t_rot_file

   task automatic t_rot_w;
      far.mem[12'h010] = 8'hE6;
      issue({OPC_RLC, 2'b00, 8'h10}, 4'h7);
      check("addr", 12'h010, rd_addr); // access bank
      check("wr_cycle", 12'h0, wr_k); // no write
      check("file", 8'hE6, far.mem[12'h010]); // file kept
      check("w", 8'hCC, w_reg); // accumulator
      check("carry", 1'b1, carry); // carry out
      far.mem[12'hF90] = 8'hD7;
      issue({OPC_RRN, 2'b00, 8'h90}, 4'h7);
      check("addr", 12'hF90, rd_addr); // access high
      check("w", 8'hEB, w_reg); // rotate right
      check("carry", 1'b1, carry); // carry kept
      far.mem[12'h77F] = 8'h00;
      issue({OPC_RLN, 2'b01, 8'h7F}, 4'h7);
      check("w", 8'h00, w_reg); // rotate left
      check("nz", 2'h1, {neg, zero}); // zero flag
   endtask : t_rot_w

   task automatic t_fill;
      far.mem[12'h533] = 8'h5A;
      issue({OPC_FILL, 1'b1, 8'h33}, 4'h5);
      check("file", FILL_VALUE, far.mem[12'h533]); // fill ones
      check("flags", 3'h5, {carry, neg, zero}); // flags kept
      far.mem[12'hF85] = 8'h00;
      issue({OPC_FILL, 1'b0, 8'h85}, 4'h5);
      check("file", 8'hFF, far.mem[12'hF85]); // access fill
      check("done_cycle", READ_DELAY + DONE_DELAY, done_k); // one cycle
   endtask : t_fill

   task automatic t_illegal;
      issue(16'hFC00, 4'h1);
      check("illegal", 1'b1, ill); // unknown word
      check("rd_cycle", 12'h0, rd_k); // no traffic
   endtask : t_illegal

   // Second word offered early, taken in Q4
   task automatic t_back_to_back;
      int n;
      n = 0;
      far.mem[12'h240] = 8'h81;
      instr_word <= {OPC_RLN, 2'b11, 8'h40};
      bank_pointer <= 4'h2;
      instr_valid <= 1'b1;
      @(posedge sys_clk);
      instr_word <= {OPC_RRN, 2'b01, 8'h40};
      for (int k = 1; k <= 10; k++) begin
         @(posedge sys_clk);
         if (k <= 4) check("ready", k == 4, instr_ready); // ready in Q4
         if (k == 4) instr_valid <= 1'b0;
         if (done === 1'b1) n++;
      end
      check("done_count", 12'h2, n); // back to back
      check("file", 8'h03, far.mem[12'h240]); // first result
      check("w", 8'h81, w_reg); // second result
      check("neg", 1'b1, neg); // negative
   endtask : t_back_to_back

   initial begin
      errors = 0;
      checked = 0;
      sys_rst = 1'b1;
      instr_valid = 1'b0;
      instr_word = '0;
      bank_pointer = '0;
      repeat (12) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      t_reset;
      t_rot_file;
      t_rot_w;
      t_fill;
      t_back_to_back;
      t_illegal;
      close_out;
   end
endmodule : rfd_datapath_tb
